// ==== alu_exec_pkg.sv ====
package alu_exec_pkg;

  // ----------------------------------------
  // Register map (word index on the port)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_OPA = 4'h0;
  localparam logic [3:0] REG_OPB = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam logic [3:0] REG_RES = 4'h3;
  localparam logic [3:0] REG_RES2 = 4'h4;
  localparam logic [3:0] REG_FLAGS = 4'h5;
  localparam logic [3:0] REG_EXT = 4'h6;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_SIZE_LSB = 5;
  localparam int unsigned CTRL_STEP_LSB = 7;
  localparam int unsigned CTRL_LEGACY_BIT = 9;
  localparam int unsigned FLG_ERR_BIT = 5;
  localparam logic [7:0] EXT_REGION_RST = 8'h01;
  localparam logic [7:0] CODE_REGION = 8'hFF;
  localparam logic [7:0] RAM_BIT_BASE = 8'h20;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [31:0] STEP_ONE = 32'h00000001;
  localparam logic [31:0] STEP_TWO = 32'h00000002;
  localparam logic [31:0] STEP_FOUR = 32'h00000004;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} state_t;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2, SZ_BAD = 2'h3
  } size_t;
  typedef enum logic [4:0] {
    OP_CMP = 5'h00, OP_INC = 5'h01, OP_DEC = 5'h02, OP_MUL = 5'h03,
    OP_DIV = 5'h04, OP_AND = 5'h05, OP_OR = 5'h06, OP_XOR = 5'h07,
    OP_SLL = 5'h08, OP_SRL = 5'h09, OP_SRA = 5'h0A, OP_SIGN_EXTEND_MOVE = 5'h0B,
    OP_ZERO_EXTEND_MOVE = 5'h0C, OP_HIGH_WORD_LOAD = 5'h0D, OP_XCH = 5'h0E, OP_DIGIT_EXCHANGE_OP = 5'h0F,
    OP_BSET = 5'h10, OP_BCLR = 5'h11, OP_BCPL = 5'h12, OP_BANL = 5'h13,
    OP_BANLN = 5'h14, OP_BORL = 5'h15, OP_BORLN = 5'h16, OP_BTOC = 5'h17,
    OP_CTOB = 5'h18, OP_PUSH = 5'h19, OP_POP = 5'h1A, OP_EXT = 5'h1B,
    OP_CODE = 5'h1C, OP_BMAP = 5'h1D
  } op_t;
  typedef struct packed {
    logic zero;
    logic neg;
    logic ac;
    logic ov;
    logic carry;
  } flags_t;

  // Operand mask for the active width
  function automatic logic [31:0] wmask(input size_t sz);
    case (sz)
      SZ_BYTE: wmask = 32'h000000FF;
      SZ_WORD: wmask = 32'h0000FFFF;
      default: wmask = 32'hFFFFFFFF;
    endcase
  endfunction

  // Top bit of the active width
  function automatic logic wmsb(input logic [31:0] v, input size_t sz);
    case (sz)
      SZ_BYTE: wmsb = v[7];
      SZ_WORD: wmsb = v[15];
      default: wmsb = v[31];
    endcase
  endfunction

  // Negative and zero from a result
  function automatic flags_t set_nz(input flags_t f, input logic [31:0] v,
                                    input size_t sz);
    set_nz = f;
    set_nz.neg = wmsb(v, sz);
    set_nz.zero = ((v & wmask(sz)) == 32'h00000000);
  endfunction
endpackage

// ==== alu_exec_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module alu_exec_unit
  import alu_exec_pkg::*;
#(
  parameter int unsigned DATA_W = 32
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Core-side status
  output logic [7:0] o_ext_region,
  output logic o_carry
);
  if (DATA_W != 32) begin : g_chk
    $error("alu_exec_unit supports DATA_W of 32 only");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    state_t st;
    logic [31:0] opa;
    logic [31:0] opb;
    op_t op;
    size_t size;
    logic [1:0] step;
    logic legacy;
    logic [31:0] res;
    logic [31:0] res2;
    flags_t flg;
    logic err;
    logic [7:0] ext;
    logic [31:0] rdata;
  } regs_t;

  regs_t s_r;
  regs_t s_nxt;
  md_if md ();

  // Multiply and divide array
  muldiv_unit u_md (
    .port(md)
  );

  // Feed the array straight from the operand registers
  assign md.wide = (s_r.size == SZ_WORD);
  assign md.a = s_r.opa[15:0];
  assign md.b = s_r.opb[15:0];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Bus writes go first and execution after, so a flag that the
  // operation sets wins over a software write in the same cycle.
  always_comb begin
    logic [31:0] m;
    logic [31:0] hb;
    logic [31:0] ma;
    logic [31:0] mb;
    logic [31:0] t;
    logic [31:0] stp;
    logic [2:0] pos;
    logic bsel;
    logic sa;
    logic sb;
    logic [7:0] baddr;
    logic bvalid;
    m = wmask(s_r.size);
    hb = m ^ (m >> 1);
    ma = s_r.opa & m;
    mb = s_r.opb & m;
    t = 32'h00000000;
    stp = 32'h00000000;
    pos = s_r.opb[2:0];
    bsel = s_r.opa[pos];
    sa = wmsb(s_r.opa, s_r.size);
    sb = wmsb(s_r.opb, s_r.size);
    baddr = 8'h00;
    bvalid = 1'b0;
    s_nxt = s_r;
    s_nxt.rdata = 32'h00000000;
    s_nxt.st = ST_IDLE;

    // Register writes
    if (i_wr) begin
      case (i_addr)
        REG_OPA: s_nxt.opa = i_wdata;
        REG_OPB: s_nxt.opb = i_wdata;
        REG_CTRL: begin
          s_nxt.op = op_t'(i_wdata[CTRL_OP_LSB +: 5]);
          s_nxt.size = size_t'(i_wdata[CTRL_SIZE_LSB +: 2]);
          s_nxt.step = i_wdata[CTRL_STEP_LSB +: 2];
          s_nxt.legacy = i_wdata[CTRL_LEGACY_BIT];
          s_nxt.st = ST_EXEC;
        end
        REG_FLAGS: begin
          s_nxt.flg = flags_t'(i_wdata[4:0]);
          s_nxt.err = i_wdata[FLG_ERR_BIT];
        end
        REG_EXT: s_nxt.ext = i_wdata[7:0];
        default: ;
      endcase
    end

    // Register reads, answered in the next cycle only
    if (i_rd) begin
      case (i_addr)
        REG_OPA: s_nxt.rdata = s_r.opa;
        REG_OPB: s_nxt.rdata = s_r.opb;
        REG_CTRL: begin
          s_nxt.rdata = {22'h000000, s_r.legacy, s_r.step, s_r.size, s_r.op};
        end
        REG_RES: s_nxt.rdata = s_r.res;
        REG_RES2: s_nxt.rdata = s_r.res2;
        REG_FLAGS: begin
          s_nxt.rdata = {25'h0000000, s_r.st == ST_EXEC, s_r.err, s_r.flg};
        end
        REG_EXT: s_nxt.rdata = {24'h000000, s_r.ext};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end

    // Execute the latched operation in the single busy cycle
    case (s_r.st)
      ST_IDLE: ;
      ST_EXEC: begin
        s_nxt.err = 1'b0;
        case (s_r.op)
          OP_CMP: begin
            // Difference only feeds the flags; no result register moves
            t = ma - mb;
            s_nxt.flg.carry = (ma < mb);
            s_nxt.flg.ov = (sa != sb) && (wmsb(t, s_r.size) != sa);
            if (s_r.size == SZ_BYTE) begin
              s_nxt.flg.ac = (ma[3:0] < mb[3:0]);
            end
            s_nxt.flg = set_nz(s_nxt.flg, t, s_r.size);
          end
          OP_INC, OP_DEC: begin
            case (s_r.step)
              2'h0: stp = STEP_ONE;
              2'h1: stp = STEP_TWO;
              2'h2: stp = STEP_FOUR;
              default: s_nxt.err = 1'b1;
            endcase
            if (!s_nxt.err) begin
              t = (s_r.op == OP_INC) ? s_r.opa + stp : s_r.opa - stp;
              s_nxt.res = (t & m) | (s_r.opa & ~m);
              s_nxt.flg = set_nz(s_nxt.flg, t, s_r.size);
            end
          end
          OP_MUL: begin
            s_nxt.flg.carry = 1'b0;
            if (s_r.size == SZ_WORD) begin
              s_nxt.res = md.prod;
              s_nxt.flg.ov = (md.prod[31:16] != 16'h0000);
              s_nxt.flg = set_nz(s_nxt.flg, md.prod, SZ_DWORD);
            end else begin
              s_nxt.res = {16'h0000, md.prod[15:0]};
              s_nxt.flg.ov = (md.prod[15:8] != 8'h00);
              s_nxt.flg = set_nz(s_nxt.flg, md.prod, SZ_WORD);
            end
          end
          OP_DIV: begin
            if (md.dz) begin
              // Destination kept; only overflow carries meaning
              s_nxt.flg.ov = 1'b1;
            end else if (s_r.size == SZ_WORD) begin
              s_nxt.res = {md.rem, md.quo};
              s_nxt.flg.ov = 1'b0;
              s_nxt.flg.carry = 1'b0;
              s_nxt.flg = set_nz(s_nxt.flg, {md.rem, md.quo}, SZ_DWORD);
            end else begin
              s_nxt.res = {16'h0000, md.rem[7:0], md.quo[7:0]};
              s_nxt.flg.ov = 1'b0;
              s_nxt.flg.carry = 1'b0;
              s_nxt.flg = set_nz(s_nxt.flg, s_nxt.res, SZ_WORD);
            end
          end
          OP_AND, OP_OR, OP_XOR: begin
            case (s_r.op)
              OP_AND: t = s_r.opa & s_r.opb;
              OP_OR: t = s_r.opa | s_r.opb;
              default: t = s_r.opa ^ s_r.opb;
            endcase
            s_nxt.res = (t & m) | (s_r.opa & ~m);
            s_nxt.flg = set_nz(s_nxt.flg, t, s_r.size);
          end
          OP_SLL, OP_SRL, OP_SRA: begin
            case (s_r.op)
              OP_SLL: begin
                t = s_r.opa << 1;
                s_nxt.flg.carry = sa;
              end
              OP_SRL: begin
                t = ma >> 1;
                s_nxt.flg.carry = s_r.opa[0];
              end
              default: begin
                t = (ma >> 1) | (sa ? hb : 32'h00000000);
                s_nxt.flg.carry = s_r.opa[0];
              end
            endcase
            s_nxt.res = (t & m) | (s_r.opa & ~m);
            s_nxt.flg = set_nz(s_nxt.flg, t, s_r.size);
          end
          OP_SIGN_EXTEND_MOVE: s_nxt.res = {16'h0000, {8{s_r.opa[7]}}, s_r.opa[7:0]};
          OP_ZERO_EXTEND_MOVE: s_nxt.res = {24'h000000, s_r.opa[7:0]};
          OP_HIGH_WORD_LOAD: s_nxt.res = {s_r.opb[15:0], s_r.opa[15:0]};
          OP_XCH: begin
            s_nxt.res = s_r.opb;
            s_nxt.res2 = s_r.opa;
          end
          OP_DIGIT_EXCHANGE_OP: begin
            s_nxt.res = {s_r.opa[31:4], s_r.opb[3:0]};
            s_nxt.res2 = {s_r.opb[31:4], s_r.opa[3:0]};
          end
          OP_PUSH: begin
            // Dword allowed on push, never a bad size
            s_nxt.err = (s_r.size == SZ_BAD);
            s_nxt.res = ma;
          end
          OP_POP: begin
            s_nxt.err = (s_r.size != SZ_BYTE) && (s_r.size != SZ_WORD);
            s_nxt.res = ma;
          end
          OP_EXT: s_nxt.res = {8'h00, s_r.ext, s_r.opa[15:0]};
          OP_CODE: s_nxt.res = {8'h00, CODE_REGION, s_r.opa[15:0]};
          OP_BSET, OP_BCLR, OP_BCPL, OP_CTOB: begin
            s_nxt.res = {24'h000000, s_r.opa[7:0]};
            case (s_r.op)
              OP_BSET: s_nxt.res[pos] = 1'b1;
              OP_BCLR: s_nxt.res[pos] = 1'b0;
              OP_BCPL: s_nxt.res[pos] = ~bsel;
              default: s_nxt.res[pos] = s_r.flg.carry;
            endcase
          end
          OP_BANL: s_nxt.flg.carry = s_r.flg.carry & bsel;
          OP_BANLN: s_nxt.flg.carry = s_r.flg.carry & ~bsel;
          OP_BORL: s_nxt.flg.carry = s_r.flg.carry | bsel;
          OP_BORLN: s_nxt.flg.carry = s_r.flg.carry | ~bsel;
          OP_BTOC: s_nxt.flg.carry = bsel;
          OP_BMAP: begin
            if (s_r.legacy) begin
              // Flat address: RAM window or SFR on an 8-byte boundary
              if (s_r.opb[7] == 1'b0) begin
                baddr = RAM_BIT_BASE + {4'h0, s_r.opb[6:3]};
              end else begin
                baddr = {s_r.opb[7:3], 3'h0};
              end
              bvalid = 1'b1;
            end else begin
              // Register and position only; no flat bit address
              baddr = s_r.opa[7:0];
              bvalid = (baddr >= RAM_BIT_BASE);
            end
            s_nxt.res = {14'h0000, bvalid, baddr >= SFR_BASE,
                         5'h00, pos, baddr};
            s_nxt.err = ~bvalid;
          end
          default: s_nxt.err = 1'b1;
        endcase
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.ext <= EXT_REGION_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register
  assign o_rdata = s_r.rdata;
  assign o_ext_region = s_r.ext;
  assign o_carry = s_r.flg.carry;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  cmp_no_store_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_CMP)
      |=> $stable(s_r.res) && $stable(s_r.res2))
    else $error("compare changed a result register");

  step_illegal_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_INC && s_r.step == 2'h3)
      |=> s_r.err && $stable(s_r.res))
    else $error("bad step size not refused");

  mul_byte_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_MUL && s_r.size == SZ_BYTE)
      |=> s_r.res[15:0] == ($past(s_r.opa[7:0]) * $past(s_r.opb[7:0])))
    else $error("byte product wrong");

  div_byte_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_DIV && s_r.size == SZ_BYTE
      && s_r.opb[7:0] != 8'h00)
      |=> s_r.res[7:0] == $past(s_r.opa[7:0]) / $past(s_r.opb[7:0])
        && s_r.res[15:8] == $past(s_r.opa[7:0]) % $past(s_r.opb[7:0]))
    else $error("byte divide packing wrong");

  div_zero_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_DIV && md.dz) |=> s_r.flg.ov)
    else $error("divide by zero did not set overflow");

  sll_byte_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_SLL && s_r.size == SZ_BYTE)
      |=> s_r.res[7:0] == {$past(s_r.opa[6:0]), 1'b0}
        && s_r.flg.carry == $past(s_r.opa[7]))
    else $error("left shift or its carry wrong");

  sra_word_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_SRA && s_r.size == SZ_WORD)
      |=> s_r.res[15:0] == {$past(s_r.opa[15]), $past(s_r.opa[15:1])})
    else $error("arithmetic shift lost the top bit");

  ext_reset_a: assert property (
    @(posedge i_mclk) $fell(i_srst) |-> o_ext_region == EXT_REGION_RST)
    else $error("region select byte not 01h after reset");

  sign_extend_move_fill_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_SIGN_EXTEND_MOVE)
      |=> s_r.res[15:8] == {8{$past(s_r.opa[7])}})
    else $error("sign extension wrong");

  bit_map_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (s_r.st == ST_EXEC && s_r.op == OP_BMAP && s_r.legacy
      && !s_r.opb[7])
      |=> s_r.res[7:0] == 8'h20 + {4'h0, $past(s_r.opb[6:3])}
        && s_r.res[10:8] == $past(s_r.opb[2:0]))
    else $error("flat bit address mapped wrong");

  read_slot_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    (i_rd && i_addr == REG_OPB) |=> o_rdata == $past(s_r.opb)
      ##1 (!$past(i_rd) -> o_rdata == 32'h00000000))
    else $error("read data not in the following cycle only");
endmodule
`default_nettype wire

// ==== arith_logic_move_bit_exec_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module arith_logic_move_bit_exec_tb_top
  import alu_exec_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus, observed outputs and tables
  // ------------------------------------------------------------
  localparam logic [31:0] M8 = 32'h000000FF;
  localparam logic [31:0] M16 = 32'h0000FFFF;
  localparam logic [31:0] MA = 32'hFFFFFFFF;
  localparam logic [31:0] BM = 32'h000307FF;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic [ADDR_W-1:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [7:0] o_ext_region;
  logic o_carry;
  int errors = 0;
  int num_checks = 0;
  int j;
  logic [1:0] k;
  logic [7:0] sh8 [3] = '{8'h02, 8'h40, 8'hC0};
  logic [15:0] sh16 [3] = '{16'hFCFC, 16'h3F3F, 16'h3F3F};
  logic [4:0] bop [5] = '{5'h17, 5'h14, 5'h16, 5'h13, 5'h15};
  logic [31:0] ba [5] = '{32'h08, 32'h08, 32'h00, 32'h00, 32'h08};
  logic [31:0] bb [5] = '{32'h3, 32'h3, 32'h0, 32'h0, 32'h3};
  logic bc [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  alu_exec_unit #(
    .DATA_W(32)
  ) i_dut (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_ext_region(o_ext_region),
    .o_carry(o_carry)
  );

  // Core clock, 40 ns period
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Each access waits for an edge first, so strobes never collide
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic rc(input logic [3:0] r, input logic [31:0] m, e);
    logic [31:0] d;
    rd(r, d);
    check($sformatf("reg%0d", r), d & m, e);
  endtask

  // Load operands, start the op, read one register back masked
  task automatic t(input logic [4:0] o, input logic [1:0] sz, st,
                   input logic lg, input logic [31:0] a, b,
                   input logic [3:0] r, input logic [31:0] m, e);
    wr(REG_OPA, a);
    wr(REG_OPB, b);
    wr(REG_CTRL, {22'h0, lg, st, sz, o});
    rc(r, m, e);
  endtask

  task automatic cc(input logic e);
    check("carry", {31'h0, o_carry}, {31'h0, e});
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    results();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_mclk);
    i_srst <= 1'b0;
    #1;
    check("region", {24'h0, o_ext_region}, 32'h01);
    cc(1'b0);
    // Compare: borrow, aux borrow, negative; equal words give zero
    t(5'h00,2'h0,2'h0,1'b0,32'h5,32'h7,REG_FLAGS,32'h1F,32'h0D);
    t(5'h00,2'h1,2'h0,1'b0,32'h1234,32'h1234,REG_FLAGS,32'h13,32'h10);
    // Every legal step on a wrapping word, then the illegal step code
    for (k = 2'h0; k != 2'h3; k++) begin
      t(5'h01,2'h1,k,1'b0,32'h1FFFE,32'h0,REG_RES,MA,
        {16'h0001, 16'hFFFE + (16'h1 << k)});
    end
    t(5'h02,2'h2,2'h2,1'b0,32'h3,32'h0,REG_RES,MA,MA);
    t(5'h02,2'h0,2'h0,1'b0,32'h1200,32'h0,REG_RES,MA,32'h12FF);
    t(5'h01,2'h0,2'h3,1'b0,32'h5,32'h0,REG_FLAGS,32'h20,32'h20);
    // Multiply and divide packing
    t(5'h03,2'h0,2'h0,1'b0,32'hF0,32'h10,REG_RES,M16,32'h0F00);
    t(5'h03,2'h1,2'h0,1'b0,M16,M16,REG_RES,MA,32'hFFFE0001);
    t(5'h04,2'h0,2'h0,1'b0,32'h64,32'h7,REG_RES,M16,32'h020E);
    t(5'h04,2'h1,2'h0,1'b0,32'h3E8,32'h7,REG_RES,MA,32'h6008E);
    t(5'h04,2'h1,2'h0,1'b0,32'h3E8,32'h0,REG_FLAGS,32'h2,32'h2);
    rc(REG_RES, MA, 32'h6008E);
    // Logic ops: zero and negative follow the result width
    t(5'h05,2'h0,2'h0,1'b0,32'hF0,32'h0F,REG_FLAGS,32'h18,32'h10);
    t(5'h06,2'h0,2'h0,1'b0,32'hF0,32'h0F,REG_FLAGS,32'h18,32'h08);
    t(5'h07,2'h1,2'h0,1'b0,32'h8000,32'h1,REG_FLAGS,32'h18,32'h08);
    rc(REG_RES, M16, 32'h8001);
    // Shifts: one pattern pushes a one out, the other a zero
    for (k = 2'h0; k != 2'h3; k++) begin
      t({3'h2,k},2'h0,2'h0,1'b0,32'h81,32'h0,REG_RES,M8,
        {24'h0, sh8[k]});
      cc(1'b1);
      t({3'h2,k},2'h1,2'h0,1'b0,32'h7E7E,32'h0,REG_RES,M16,
        {16'h0, sh16[k]});
      cc(1'b0);
    end
    // Moves and exchanges
    wr(REG_EXT, 32'h3C);
    // The write lands at the edge the task returns on; let it settle
    #1;
    check("region", {24'h0, o_ext_region}, 32'h3C);
    t(5'h1B,2'h0,2'h0,1'b0,32'h1234,32'h0,REG_RES,MA,32'h3C1234);
    t(5'h1C,2'h0,2'h0,1'b0,32'h1234,32'h0,REG_RES,MA,32'hFF1234);
    t(5'h0B,2'h0,2'h0,1'b0,32'h85,32'h0,REG_RES,M16,32'hFF85);
    t(5'h0C,2'h0,2'h0,1'b0,32'h85,32'h0,REG_RES,M16,32'h0085);
    t(5'h0D,2'h2,2'h0,1'b0,32'h5678,32'hABCD,REG_RES,MA,32'hABCD5678);
    t(5'h00,2'h0,2'h0,1'b0,32'h1,32'h1,REG_RES,MA,32'hABCD5678);
    t(5'h0E,2'h0,2'h0,1'b0,32'h11,32'h22,REG_RES,M8,32'h22);
    rc(REG_RES2, M8, 32'h11);
    t(5'h0F,2'h0,2'h0,1'b0,32'hA5,32'h3C,REG_RES,M8,32'hAC);
    rc(REG_RES2, M8, 32'h35);
    // Stack widths: dword pushes, never pops
    t(5'h19,2'h2,2'h0,1'b0,32'h1,32'h0,REG_FLAGS,32'h20,32'h0);
    t(5'h19,2'h3,2'h0,1'b0,32'h1,32'h0,REG_FLAGS,32'h20,32'h20);
    t(5'h1A,2'h2,2'h0,1'b0,32'h1,32'h0,REG_FLAGS,32'h20,32'h20);
    t(5'h1A,2'h1,2'h0,1'b0,32'h1,32'h0,REG_FLAGS,32'h20,32'h0);
    // Single-bit ops, carry chain started from a cleared flag word
    t(5'h10,2'h0,2'h0,1'b0,32'h00,32'h3,REG_RES,M8,32'h08);
    t(5'h11,2'h0,2'h0,1'b0,32'hFF,32'h3,REG_RES,M8,32'hF7);
    t(5'h12,2'h0,2'h0,1'b0,32'h0F,32'h0,REG_RES,M8,32'h0E);
    wr(REG_FLAGS, 32'h0);
    cc(1'b0);
    for (j = 0; j < 5; j++) begin
      t(bop[j],2'h0,2'h0,1'b0,ba[j],bb[j],REG_FLAGS,32'h1,
        {31'h0, bc[j]});
      cc(bc[j]);
    end
    t(5'h18,2'h0,2'h0,1'b0,32'h00,32'h5,REG_RES,M8,32'h20);
    // Bit address mapping, legacy flat and new register form
    t(5'h1D,2'h0,2'h0,1'b1,32'h0,32'h1D,REG_RES,BM,32'h20523);
    t(5'h1D,2'h0,2'h0,1'b1,32'h0,32'h7F,REG_RES,BM,32'h2072F);
    t(5'h1D,2'h0,2'h0,1'b1,32'h0,32'h8A,REG_RES,BM,32'h30288);
    t(5'h1D,2'h0,2'h0,1'b0,32'h7F,32'h7,REG_RES,BM,32'h2077F);
    t(5'h1D,2'h0,2'h0,1'b0,32'h9A,32'h1,REG_RES,BM,32'h3019A);
    t(5'h1D,2'h0,2'h0,1'b0,32'h1F,32'h1,REG_FLAGS,32'h20,32'h20);
    // Unmapped index and unknown op code
    wr(4'h7, MA);
    rc(4'h7, MA, 32'h0);
    t(5'h1E,2'h0,2'h0,1'b0,32'h1,32'h1,REG_FLAGS,32'h20,32'h20);
    // Operand read-back exercises the one-cycle read slot
    rc(REG_OPB, MA, 32'h1);
    // Second reset in mid-run restores the region byte
    @(posedge i_mclk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    #1;
    check("region", {24'h0, o_ext_region}, 32'h01);
    cc(1'b0);
    results();
  end
endmodule
`default_nettype wire

// ==== md_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface md_if;
  logic wide;
  logic [15:0] a;
  logic [15:0] b;
  logic [31:0] prod;
  logic [15:0] quo;
  logic [15:0] rem;
  logic dz;
  modport ctl (output wide, a, b, input prod, quo, rem, dz);
  modport unit (input wide, a, b, output prod, quo, rem, dz);
endinterface
`default_nettype wire

// ==== muldiv_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module muldiv_unit #(
  parameter int unsigned HALF_W = 16
) (
  // Operands in, results out
  md_if.unit port
);
  if (HALF_W != 16) begin : g_chk
    $error("muldiv_unit supports HALF_W of 16 only");
  end

  // ----------------------------------------
  // Unsigned multiply and divide
  // ----------------------------------------
  // Combinational on purpose: at 25 MHz a 16-bit array fits one cycle,
  // which keeps the issuing sequencer free of multi-cycle stalls.
  always_comb begin
    logic [15:0] na;
    logic [15:0] nb;
    na = port.wide ? port.a : {8'h00, port.a[7:0]};
    nb = port.wide ? port.b : {8'h00, port.b[7:0]};
    port.prod = {16'h0000, na} * {16'h0000, nb};
    port.dz = (nb == 16'h0000);
    if (port.dz) begin
      // Divider output is don't-care; zero keeps it defined
      port.quo = 16'h0000;
      port.rem = 16'h0000;
    end else begin
      port.quo = na / nb;
      port.rem = na % nb;
    end
  end
endmodule
`default_nettype wire
